// ---- core/gusr_pkg.sv ----
// package of constants for the global unlock and soft reset command decoder
// assumes: a flash core clock of 125 MHz and a link clock from the host
package gusr_pkg;
  localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET_EXEC = 8'h99;
  localparam int unsigned FRAME_BITS = 8;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned RESET_TIME_US = 30;
  localparam int unsigned RESET_CYCLES = RESET_TIME_US * CLK_MHZ;
  localparam logic [7:0] READ_PARAM_RST = 8'h00;
  localparam logic [7:0] CONT_MODE_RST = 8'h00;
  localparam logic [2:0] WRAP_RST = 3'h0;
  localparam logic [7:0] VOL_STATUS_RST = 8'h00;
endpackage

// ---- core/gusr_frame_if.sv ----
// interface carrying completed opcode frames from link to core domain
// assumes: toggle-based event crossing, opcode held stable until next frame
interface gusr_frame_if;
  logic frame_tgl;
  logic [7:0] frame_op;
  modport link (output frame_tgl, output frame_op);
  modport core (input frame_tgl, input frame_op);
endinterface

// ---- core/gusr_link_rx.sv ----
// link-side opcode shifter on the host serial clock
// assumes: chip select low frames a command; the host clock stops between frames
module gusr_link_rx (
  // core reset, only clears the frame toggle and the posted opcode
  input wire logic reset_n,
  // link pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  input wire logic four_wire_mode,
  // core side
  gusr_frame_if.link frame
);
  // ----------------------------------------
  // opcode shift, bits on rising sck edges
  // ----------------------------------------
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic tgl_r;
  logic tgl_nxt;
  logic [7:0] op_r;
  logic [7:0] op_nxt;

  always_comb
  begin
    if (four_wire_mode)
    begin
      shift_nxt = {shift_r[3:0], io_in};
      cnt_nxt = (cnt_r > 4'h8) ? cnt_r : cnt_r + 4'h4;
    end
    else
    begin
      shift_nxt = {shift_r[6:0], io_in[0]};
      cnt_nxt = (cnt_r > 4'h8) ? cnt_r : cnt_r + 4'h1;
    end
  end

  // reset by chip select high between frames
  always_ff @(posedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      shift_r <= 8'h00;
      cnt_r <= 4'h0;
    end
    else
    begin
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------
  // frame end: rising chip select posts the opcode
  // ----------------------------------------
  always_comb
  begin
    tgl_nxt = tgl_r;
    op_nxt = op_r;
    if (cnt_r != 4'h0)
    begin
      tgl_nxt = ~tgl_r;
      // frames of other than 8 bits post an illegal marker so they still disarm
      op_nxt = (cnt_r == 4'(gusr_pkg::FRAME_BITS)) ? shift_r : 8'h00;
    end
  end

  // toggle must start known or the crossing never sees an edge
  always_ff @(posedge cs_n or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tgl_r <= 1'b0;
      op_r <= 8'h00;
    end
    else
    begin
      tgl_r <= tgl_nxt;
      op_r <= op_nxt;
    end
  end

  assign frame.frame_tgl = tgl_r;
  assign frame.frame_op = op_r;
endmodule

// ---- core/gusr_top.sv ----
// global unlock and two-step soft reset command decoder
// assumes: host drives chip select, serial clock and data; core clock 125 MHz
module gusr_top #(
  parameter int unsigned RESET_CYCLES = gusr_pkg::RESET_CYCLES,
  parameter int unsigned LOCK_BITS = 16
) (
  // core clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // link pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  // mode in
  input wire logic four_wire_mode,
  // state to the rest of the flash
  output logic [LOCK_BITS-1:0] lock_bits,
  output logic reset_armed,
  output logic reset_busy,
  output logic abort_op,
  output logic write_enable_latch,
  output logic suspend_flag,
  output logic [7:0] read_parameter_bits,
  output logic [7:0] continuous_read_mode_bits,
  output logic [2:0] wrap_setting_bits,
  output logic [7:0] volatile_status,
  // updates to volatile settings from other commands
  input wire logic wel_set,
  input wire logic wel_clr,
  input wire logic suspend_set,
  input wire logic suspend_clr,
  input wire logic settings_load,
  input wire logic [7:0] read_param_in,
  input wire logic [7:0] cont_mode_in,
  input wire logic [2:0] wrap_in,
  input wire logic [7:0] vol_status_in,
  input wire logic lock_load,
  input wire logic [LOCK_BITS-1:0] lock_in
);
  localparam int unsigned CW = $clog2(RESET_CYCLES + 1);

  if (RESET_CYCLES < 1 || LOCK_BITS < 1)
  begin : g_bad_params
    $error("gusr_top: bad parameters");
  end

  gusr_frame_if frame ();

  gusr_link_rx u_rx (
    .reset_n(reset_n),
    .sck(sck),
    .cs_n(cs_n),
    .io_in(io_in),
    .four_wire_mode(four_wire_mode),
    .frame(frame.link)
  );

  // ----------------------------------------
  // crossing: three-stage toggle, opcode through two stages sampled every cycle
  // ----------------------------------------
  logic [2:0] tsync_r;
  logic [2:0] tsync_nxt;
  logic [7:0] op_s1_r;
  logic [7:0] op_s2_r;
  logic [7:0] op_s1_nxt;
  logic [7:0] op_s2_nxt;
  logic frame_seen;

  always_comb
  begin
    tsync_nxt = {tsync_r[1:0], frame.frame_tgl};
    op_s1_nxt = frame.frame_op;
    op_s2_nxt = op_s1_r;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tsync_r <= 3'h0;
      op_s1_r <= 8'h00;
      op_s2_r <= 8'h00;
    end
    else
    begin
      tsync_r <= tsync_nxt;
      op_s1_r <= op_s1_nxt;
      op_s2_r <= op_s2_nxt;
    end
  end

  // opcode word taken from stage two when the toggle edge shows
  assign frame_seen = tsync_r[2] ^ tsync_r[1];

  // ----------------------------------------
  // command state machine
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_RESET = 3'b100
  } gusr_state_t;

  gusr_state_t state_r;
  gusr_state_t state_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic do_unlock;
  logic do_reset;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    do_unlock = 1'b0;
    do_reset = 1'b0;
    unique case (state_r)
      ST_IDLE:
      begin
        if (frame_seen && op_s2_r == gusr_pkg::OP_RESET_ARM)
          state_nxt = ST_ARMED;
        else if (frame_seen && op_s2_r == gusr_pkg::OP_GLOBAL_UNLOCK)
          do_unlock = 1'b1;
      end
      ST_ARMED:
      begin
        if (frame_seen)
        begin
          if (op_s2_r == gusr_pkg::OP_RESET_EXEC)
          begin
            state_nxt = ST_RESET;
            cnt_nxt = CW'(RESET_CYCLES);
            do_reset = 1'b1;
          end
          else if (op_s2_r == gusr_pkg::OP_RESET_ARM)
            state_nxt = ST_ARMED;
          else
          begin
            state_nxt = ST_IDLE;
            do_unlock = (op_s2_r == gusr_pkg::OP_GLOBAL_UNLOCK);
          end
        end
      end
      ST_RESET:
      begin
        // frames during recovery are dropped
        if (cnt_r <= CW'(1))
        begin
          state_nxt = ST_IDLE;
          cnt_nxt = '0;
        end
        else
          cnt_nxt = cnt_r - CW'(1);
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------
  // volatile settings and lock bits
  // ----------------------------------------
  logic [LOCK_BITS-1:0] lock_r;
  logic [LOCK_BITS-1:0] lock_nxt;
  logic wel_r;
  logic wel_nxt;
  logic sus_r;
  logic sus_nxt;
  logic [7:0] rp_r;
  logic [7:0] rp_nxt;
  logic [7:0] cm_r;
  logic [7:0] cm_nxt;
  logic [2:0] wr_r;
  logic [2:0] wr_nxt;
  logic [7:0] vs_r;
  logic [7:0] vs_nxt;
  logic abort_r;
  logic abort_nxt;

  always_comb
  begin
    lock_nxt = lock_load ? lock_in : lock_r;
    wel_nxt = wel_set ? 1'b1 : (wel_clr ? 1'b0 : wel_r);
    sus_nxt = suspend_set ? 1'b1 : (suspend_clr ? 1'b0 : sus_r);
    rp_nxt = settings_load ? read_param_in : rp_r;
    cm_nxt = settings_load ? cont_mode_in : cm_r;
    wr_nxt = settings_load ? wrap_in : wr_r;
    vs_nxt = settings_load ? vol_status_in : vs_r;
    abort_nxt = do_reset;
    if (do_unlock)
      lock_nxt = '0;
    if (do_reset)
    begin
      lock_nxt = '1;
      wel_nxt = 1'b0;
      sus_nxt = 1'b0;
      rp_nxt = gusr_pkg::READ_PARAM_RST;
      cm_nxt = gusr_pkg::CONT_MODE_RST;
      wr_nxt = gusr_pkg::WRAP_RST;
      vs_nxt = gusr_pkg::VOL_STATUS_RST;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lock_r <= '1;
      wel_r <= 1'b0;
      sus_r <= 1'b0;
      rp_r <= gusr_pkg::READ_PARAM_RST;
      cm_r <= gusr_pkg::CONT_MODE_RST;
      wr_r <= gusr_pkg::WRAP_RST;
      vs_r <= gusr_pkg::VOL_STATUS_RST;
      abort_r <= 1'b0;
    end
    else
    begin
      lock_r <= lock_nxt;
      wel_r <= wel_nxt;
      sus_r <= sus_nxt;
      rp_r <= rp_nxt;
      cm_r <= cm_nxt;
      wr_r <= wr_nxt;
      vs_r <= vs_nxt;
      abort_r <= abort_nxt;
    end
  end

  assign lock_bits = lock_r;
  assign reset_armed = (state_r == ST_ARMED);
  assign reset_busy = (state_r == ST_RESET);
  assign abort_op = abort_r;
  assign write_enable_latch = wel_r;
  assign suspend_flag = sus_r;
  assign read_parameter_bits = rp_r;
  assign continuous_read_mode_bits = cm_r;
  assign wrap_setting_bits = wr_r;
  assign volatile_status = vs_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_unlock_clears;
    @(posedge core_clk) disable iff (!reset_n)
    (state_r == ST_IDLE && frame_seen && op_s2_r == gusr_pkg::OP_GLOBAL_UNLOCK)
      |=> (lock_bits == '0);
  endproperty
  a_unlock_clears: assert property (p_unlock_clears) else $error("unlock did not clear locks");

  property p_reset_locks;
    @(posedge core_clk) disable iff (!reset_n)
    $rose(reset_busy) |-> (lock_bits == '1 && abort_op);
  endproperty
  a_reset_locks: assert property (p_reset_locks) else $error("reset left locks open");

  property p_reset_clears_volatile;
    @(posedge core_clk) disable iff (!reset_n)
    $rose(reset_busy) |-> (!write_enable_latch && !suspend_flag && wrap_setting_bits == '0
      && read_parameter_bits == '0 && continuous_read_mode_bits == '0);
  endproperty
  a_reset_clears_volatile: assert property (p_reset_clears_volatile) else $error("volatile kept");

  property p_abort_pulse;
    @(posedge core_clk) disable iff (!reset_n)
    abort_op |=> !abort_op;
  endproperty
  a_abort_pulse: assert property (p_abort_pulse) else $error("abort not a pulse");

  property p_exec_needs_arm;
    @(posedge core_clk) disable iff (!reset_n)
    $rose(reset_busy) |-> $past(reset_armed);
  endproperty
  a_exec_needs_arm: assert property (p_exec_needs_arm) else $error("reset without arm");

  property p_disarm;
    @(posedge core_clk) disable iff (!reset_n)
    (reset_armed && frame_seen && op_s2_r != gusr_pkg::OP_RESET_EXEC
      && op_s2_r != gusr_pkg::OP_RESET_ARM) |=> !reset_armed && !reset_busy;
  endproperty
  a_disarm: assert property (p_disarm) else $error("arm not dropped");

  property p_busy_locks_stable;
    @(posedge core_clk) disable iff (!reset_n)
    (reset_busy && !lock_load) |=> $stable(lock_bits);
  endproperty
  a_busy_locks_stable: assert property (p_busy_locks_stable) else $error("cmd during reset");

  property p_busy_count;
    @(posedge core_clk) disable iff (!reset_n)
    $rose(reset_busy) |-> (cnt_r == CW'(RESET_CYCLES));
  endproperty
  a_busy_count: assert property (p_busy_count) else $error("wrong reset length");
endmodule

// ---- verif/gusr_host_model.sv ----
// host model driving chip select, serial clock and data lines
// assumes: link clock of 160 ns that stands still between frames
module gusr_host_model #(
  parameter int unsigned PUW_NS = 5_000_000
) (
  // link pins
  output logic sck,
  output logic cs_n,
  output logic [3:0] io_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    io_out = 4'h0;
  end

  // ----------------------------------------
  // one frame, msb first, n bits from the top
  // ----------------------------------------
  task automatic send_frame(input logic [15:0] bits, input int n, input logic fw);
    int i;
    i = 0;
    while ($realtime < PUW_NS)
      #100;
    #37;
    cs_n = 1'b0;
    while (i < n)
    begin
      if (fw)
        io_out = bits[15-i -: 4];
      else
        io_out = {~io_out[3:1], bits[15-i]};
      #80 sck = 1'b1;
      #80 sck = 1'b0;
      i += fw ? 4 : 1;
    end
    #40 cs_n = 1'b1;
    io_out = ~io_out;
    #480;
  endtask
endmodule

// ---- verif/gusr_top_test.sv ----
// self-checking bench for the unlock and soft reset decoder
// assumes: host model on the link pins, bench drives the rest on falling edges
module gusr_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned RST_CYC = 300;
  logic core_clk, reset_n, sck, cs_n, four_wire_mode;
  logic [3:0] io_in;
  logic [15:0] lock_bits, lock_in;
  logic reset_armed, reset_busy, abort_op, write_enable_latch, suspend_flag;
  logic [7:0] read_parameter_bits, continuous_read_mode_bits, volatile_status;
  logic [7:0] read_param_in, cont_mode_in, vol_status_in;
  logic [2:0] wrap_setting_bits, wrap_in;
  logic wel_set, wel_clr, suspend_set, suspend_clr, settings_load, lock_load;
  int errors, checks_done, busy_cnt, abort_cnt, w;

  gusr_top #(.RESET_CYCLES(RST_CYC), .LOCK_BITS(16)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .io_in(io_in),
    .four_wire_mode(four_wire_mode), .lock_bits(lock_bits), .reset_armed(reset_armed),
    .reset_busy(reset_busy), .abort_op(abort_op), .write_enable_latch(write_enable_latch),
    .suspend_flag(suspend_flag), .read_parameter_bits(read_parameter_bits),
    .continuous_read_mode_bits(continuous_read_mode_bits),
    .wrap_setting_bits(wrap_setting_bits), .volatile_status(volatile_status),
    .wel_set(wel_set), .wel_clr(wel_clr), .suspend_set(suspend_set),
    .suspend_clr(suspend_clr), .settings_load(settings_load),
    .read_param_in(read_param_in), .cont_mode_in(cont_mode_in), .wrap_in(wrap_in),
    .vol_status_in(vol_status_in), .lock_load(lock_load), .lock_in(lock_in));

  gusr_host_model #(.PUW_NS(2000)) host (.sck(sck), .cs_n(cs_n), .io_out(io_in));

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    if (reset_busy === 1'b1)
      busy_cnt++;
    if (abort_op === 1'b1)
      abort_cnt++;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic frame(input logic [7:0] op, input int n, input logic fw);
    @(negedge core_clk);
    four_wire_mode = fw;
    host.send_frame({op, 8'h80}, n, fw);
    repeat (8) @(negedge core_clk);
  endtask

  // set and clear together: set wins
  task automatic load_all;
    @(negedge core_clk);
    {wel_set, wel_clr, suspend_set, suspend_clr, settings_load, lock_load} = 6'h3f;
    @(negedge core_clk);
    {wel_set, wel_clr, suspend_set, suspend_clr, settings_load, lock_load} = 6'h00;
    @(negedge core_clk);
    check({write_enable_latch, suspend_flag, read_parameter_bits, continuous_read_mode_bits,
      wrap_setting_bits, volatile_status}, {1'b1, 1'b1, 8'ha5, 8'h3c, 3'h5, 8'h81});
    check(lock_bits, 16'h5a5a);
  endtask

  initial
  begin
    #200_000;
    errors++;
    end_sim;
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    {reset_n, four_wire_mode, wel_set, wel_clr, suspend_set, suspend_clr} = 6'h00;
    {settings_load, lock_load} = 2'h0;
    lock_in = 16'h5a5a;
    read_param_in = 8'ha5;
    cont_mode_in = 8'h3c;
    wrap_in = 3'h5;
    vol_status_in = 8'h81;
    {errors, checks_done, busy_cnt, abort_cnt} = '0;
    repeat (8) @(negedge core_clk);
    reset_n = 1'b1;
    @(negedge core_clk);
    check(lock_bits, 16'hffff);
    check({reset_armed, reset_busy, write_enable_latch, suspend_flag}, 32'h0);
    load_all;
    frame(gusr_pkg::OP_RESET_EXEC, 8, 1'b0);
    check({reset_busy, lock_bits}, {1'b0, 16'h5a5a});
    frame(gusr_pkg::OP_GLOBAL_UNLOCK, 7, 1'b0);
    check(lock_bits, 16'h5a5a);
    frame(gusr_pkg::OP_GLOBAL_UNLOCK, 9, 1'b0);
    check(lock_bits, 16'h5a5a);
    frame(gusr_pkg::OP_GLOBAL_UNLOCK, 8, 1'b0);
    check(lock_bits, 16'h0000);
    load_all;
    frame(gusr_pkg::OP_RESET_ARM, 8, 1'b0);
    check(reset_armed, 1'b1);
    frame(8'h05, 8, 1'b0);
    check(reset_armed, 1'b0);
    frame(gusr_pkg::OP_RESET_EXEC, 8, 1'b0);
    check({reset_busy, lock_bits}, {1'b0, 16'h5a5a});
    for (int fw = 0; fw < 2; fw++)
    begin
      load_all;
      busy_cnt = 0;
      abort_cnt = 0;
      check({reset_busy, reset_armed}, 2'h0);
      frame(gusr_pkg::OP_RESET_ARM, 8, fw[0]);
      frame(gusr_pkg::OP_RESET_EXEC, 8, fw[0]);
      check({reset_busy, reset_armed}, 2'h2);
      check(lock_bits, 16'hffff);
      check({write_enable_latch, suspend_flag, read_parameter_bits, continuous_read_mode_bits,
        wrap_setting_bits, volatile_status}, 32'h0);
      frame(gusr_pkg::OP_GLOBAL_UNLOCK, 8, 1'b1);
      check(lock_bits, 16'hffff);
      w = 0;
      while (w < 1000 && reset_busy !== 1'b0)
      begin
        @(negedge core_clk);
        w++;
      end
      check(busy_cnt, RST_CYC);
      check(abort_cnt, 1);
      frame(gusr_pkg::OP_GLOBAL_UNLOCK, 8, fw[0]);
      check(lock_bits, 16'h0000);
    end
    end_sim;
  end
endmodule
